// [design/pgp_pkg.sv]
package pgp_pkg;
	localparam int PGP_NPORT = 4;
	localparam logic [7:0] PGP_ADDR_PAGE = 8'hb2;
	localparam logic [7:0] PGP_ADDR_VAL0 = 8'h80;
	localparam logic [7:0] PGP_ADDR_DIR0 = 8'h86;
	localparam logic [7:0] PGP_ADDR_VAL1 = 8'h90;
	localparam logic [7:0] PGP_ADDR_DIR1 = 8'h91;
	localparam logic [7:0] PGP_ADDR_VAL2 = 8'ha0;
	localparam logic [7:0] PGP_ADDR_DIR2 = 8'ha1;
	localparam logic [7:0] PGP_ADDR_VAL3 = 8'hb0;
	localparam logic [7:0] PGP_ADDR_DIR3 = 8'hb1;
	localparam logic [7:0] PGP_MASK0 = 8'h3f;
	localparam logic [7:0] PGP_MASK1 = 8'he3;
	localparam logic [7:0] PGP_MASK2 = 8'hff;
	localparam logic [7:0] PGP_MASK3 = 8'hff;
	localparam int PGP_OP_HI = 7;
	localparam int PGP_OP_LO = 6;
	localparam int PGP_SLOT_HI = 5;
	localparam int PGP_SLOT_LO = 4;
	localparam int PGP_PAGE_HI = 2;
	localparam int PGP_PAGE_LO = 0;
	localparam logic [1:0] PGP_OP_SAVE = 2'h2;
	localparam logic [1:0] PGP_OP_RESTORE = 2'h3;
	localparam logic [2:0] PGP_PAGE_PORTS = 3'h0;
	localparam logic [7:0] PGP_RESET_BYTE = 8'h00;
	localparam logic [2:0] PGP_RESET_PAGE = 3'h0;
	localparam logic [1:0] PGP_RESET_SLOT = 2'h0;
endpackage

// [design/pgp_port_sfr.sv]
`timescale 1ns/1ps
// Behaviour
// R1: Operation bits 7:6 write-only; 0x loads page directly
// R2: Code 10 saves old page into slot
// R3: Code 11 restores page from chosen slot
// R4: Reserved bit 3 reads back zero
// R5: Port registers decoded only with standard map
// R6: Page register resets to zero
// R7: Direction drives pin; data reads pin level
module pgp_port_sfr
	import pgp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic register_map_select_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_rvalid_o,
	input wire logic [31:0] pin_in_i,
	output logic [31:0] pin_out_o,
	output logic [31:0] pin_oe_o
);
	typedef struct packed {
		logic [2:0] page;
		logic [1:0] slot;
		logic [3:0][2:0] store;
		logic [3:0][7:0] value;
		logic [3:0][7:0] dir;
		logic [31:0] sync1;
		logic [31:0] sync2;
		logic [7:0] rdata;
		logic rvalid;
	} pgp_state_t;

	pgp_state_t s_q;
	pgp_state_t s_d;

	// Returns {hit, is_direction, port index}
	function automatic logic [3:0] pgp_decode(input logic [7:0] addr);
		logic [3:0] r;
		r = 4'h0;
		if (addr == PGP_ADDR_VAL0) begin
			r = 4'h8;
		end else if (addr == PGP_ADDR_DIR0) begin
			r = 4'hc;
		end else if (addr == PGP_ADDR_VAL1) begin
			r = 4'h9;
		end else if (addr == PGP_ADDR_DIR1) begin
			r = 4'hd;
		end else if (addr == PGP_ADDR_VAL2) begin
			r = 4'ha;
		end else if (addr == PGP_ADDR_DIR2) begin
			r = 4'he;
		end else if (addr == PGP_ADDR_VAL3) begin
			r = 4'hb;
		end else if (addr == PGP_ADDR_DIR3) begin
			r = 4'hf;
		end
		return r;
	endfunction

	function automatic logic [7:0] pgp_mask(input logic [1:0] idx);
		logic [7:0] m;
		m = PGP_MASK3;
		if (idx == 2'h0) begin
			m = PGP_MASK0;
		end else if (idx == 2'h1) begin
			m = PGP_MASK1;
		end else if (idx == 2'h2) begin
			m = PGP_MASK2;
		end
		return m;
	endfunction

	logic [3:0] dec;
	logic dec_hit;
	logic dec_dir;
	logic [1:0] dec_idx;

	logic std_map;
	logic page_sel;
	logic ports_page;
	logic port_hit;

	logic [1:0] op;
	logic [1:0] wslot;
	logic [2:0] wpage;
	logic page_wr;
	logic page_rd;
	logic op_save;
	logic port_wr;
	logic port_rd;

	logic [3:0] val_wr;
	logic [3:0] dir_wr;
	logic [3:0] val_rd;
	logic [3:0] dir_rd;
	logic [3:0][7:0] port_mask;
	logic [3:0][7:0] pin_level;
	logic [7:0] page_rdata;

	// True for the page register in the standard map
	function automatic logic pgp_is_page(
		input logic [7:0] addr,
		input logic map_sel
	);
		logic hit;
		hit = 1'b0;
		// R5: standard map only
		if (!map_sel && (addr == PGP_ADDR_PAGE)) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	// True while the port bank is selected
	function automatic logic pgp_page_ok(
		input logic [2:0] page
	);
		logic ok;
		ok = (page == PGP_PAGE_PORTS);
		return ok;
	endfunction

	// True when a decoded port index names port idx
	function automatic logic pgp_sel(
		input logic [1:0] got,
		input logic [1:0] idx
	);
		logic s;
		s = (got == idx);
		return s;
	endfunction

	// Keeps only the implemented bits of a port byte
	function automatic logic [7:0] pgp_masked(
		input logic [7:0] data,
		input logic [7:0] keep
	);
		logic [7:0] r;
		r = data & keep;
		return r;
	endfunction

	// Read-back byte of the page register
	function automatic logic [7:0] pgp_page_byte(
		input logic [1:0] slot,
		input logic [2:0] page
	);
		logic [7:0] b;
		// R1: operation field reads zero
		// R4: reserved bit zero
		b = PGP_RESET_BYTE;
		b[PGP_SLOT_HI:PGP_SLOT_LO] = slot;
		b[PGP_PAGE_HI:PGP_PAGE_LO] = page;
		return b;
	endfunction

	// Page value after one write of the page register
	function automatic logic [2:0] pgp_next_page(
		input logic [1:0] op_code,
		input logic [2:0] new_page,
		input logic [2:0] stored_page
	);
		logic [2:0] p;
		p = new_page;
		if (op_code == PGP_OP_RESTORE) begin
			// R3: restore from slot
			p = stored_page;
		end else if (op_code == PGP_OP_SAVE) begin
			// R2: new page taken
			p = new_page;
		end else begin
			// R1: direct page load
			p = new_page;
		end
		return p;
	endfunction

	// Slot number after one write of the page register
	function automatic logic [1:0] pgp_next_slot(
		input logic [1:0] op_code,
		input logic [1:0] cur_slot,
		input logic [1:0] new_slot
	);
		logic [1:0] n;
		n = cur_slot;
		// R1: slot ignored when manual
		if (op_code[1]) begin
			n = new_slot;
		end
		return n;
	endfunction

	// Byte returned by a port register read
	function automatic logic [7:0] pgp_port_byte(
		input logic is_dir,
		input logic [7:0] dir,
		input logic [7:0] level
	);
		logic [7:0] r;
		r = level;
		if (is_dir) begin
			r = dir;
		end
		return r;
	endfunction

	assign dec = pgp_decode(sfr_addr_i);
	assign dec_hit = dec[3];
	assign dec_dir = dec[2];
	assign dec_idx = dec[1:0];

	assign std_map = ~register_map_select_i;
	assign page_sel = pgp_is_page(sfr_addr_i, register_map_select_i);
	assign ports_page = pgp_page_ok(s_q.page);
	// R5: ports only in standard map
	assign port_hit = std_map && dec_hit && ports_page;

	assign op = sfr_wdata_i[PGP_OP_HI:PGP_OP_LO];
	assign wslot = sfr_wdata_i[PGP_SLOT_HI:PGP_SLOT_LO];
	assign wpage = sfr_wdata_i[PGP_PAGE_HI:PGP_PAGE_LO];
	assign page_wr = sfr_wr_i && page_sel;
	assign page_rd = sfr_rd_i && page_sel;
	assign op_save = page_wr && (op == PGP_OP_SAVE);
	assign port_wr = sfr_wr_i && port_hit;
	assign port_rd = sfr_rd_i && port_hit;
	assign page_rdata = pgp_page_byte(s_q.slot, s_q.page);

	// Per-port strobes, masks and pin levels
	for (genvar g = 0; g < PGP_NPORT; g++) begin : g_port
		assign port_mask[g] = pgp_mask(2'(g));
		assign val_wr[g] = port_wr && !dec_dir && pgp_sel(dec_idx, 2'(g));
		assign dir_wr[g] = port_wr && dec_dir && pgp_sel(dec_idx, 2'(g));
		assign val_rd[g] = port_rd && !dec_dir && pgp_sel(dec_idx, 2'(g));
		assign dir_rd[g] = port_rd && dec_dir && pgp_sel(dec_idx, 2'(g));
		// R7: pin level masked
		assign pin_level[g] = pgp_masked(s_q.sync2[g * 8 +: 8], port_mask[g]);
	end

	always_comb begin
		s_d = s_q;
		s_d.sync1 = pin_in_i;
		s_d.sync2 = s_q.sync1;
		s_d.rvalid = sfr_rd_i;
		s_d.rdata = PGP_RESET_BYTE;

		if (page_wr) begin
			s_d.page = pgp_next_page(op, wpage, s_q.store[wslot]);
			s_d.slot = pgp_next_slot(op, s_q.slot, wslot);
		end

		if (op_save) begin
			// R2: save old page
			s_d.store[wslot] = s_q.page;
		end

		// R7: masked register writes
		for (int i = 0; i < PGP_NPORT; i++) begin
			if (val_wr[i]) begin
				s_d.value[i] = pgp_masked(sfr_wdata_i, port_mask[i]);
			end
			if (dir_wr[i]) begin
				s_d.dir[i] = pgp_masked(sfr_wdata_i, port_mask[i]);
			end
		end

		if (page_rd) begin
			s_d.rdata = page_rdata;
		end

		for (int i = 0; i < PGP_NPORT; i++) begin
			if (val_rd[i] || dir_rd[i]) begin
				// R7: data read gives pin level, direction read gives register
				s_d.rdata = pgp_port_byte(dir_rd[i], s_q.dir[i], pin_level[i]);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// R6: page register zero
			s_q.page <= PGP_RESET_PAGE;
			s_q.slot <= PGP_RESET_SLOT;
			for (int i = 0; i < PGP_NPORT; i++) begin
				s_q.store[i] <= PGP_RESET_PAGE;
				s_q.value[i] <= PGP_RESET_BYTE;
				s_q.dir[i] <= PGP_RESET_BYTE;
			end
			s_q.sync1 <= '0;
			s_q.sync2 <= '0;
			s_q.rdata <= PGP_RESET_BYTE;
			s_q.rvalid <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end


	assign sfr_rdata_o = s_q.rdata;
	assign sfr_rvalid_o = s_q.rvalid;
	// R7: direction enables drive
	assign pin_out_o = s_q.value;
	assign pin_oe_o = s_q.dir;
endmodule

// [tb/pgp_port_sfr_props.sv]
`timescale 1ns/1ps
module pgp_port_sfr_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic register_map_select_i,
	input wire logic sfr_rvalid_o,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic [31:0] pin_out_o,
	input wire logic [31:0] pin_oe_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire wp = sfr_wr_i && !register_map_select_i && sfr_addr_i == 8'hb2;
	wire rp = sfr_rd_i && !sfr_wr_i && !register_map_select_i && sfr_addr_i == 8'hb2;
	property p_ld; wp && sfr_wdata_i[7] == 1'b0 ##1 rp |=> sfr_rdata_o[2:0] == $past(sfr_wdata_i[2:0], 2); endproperty
	a_ld: assert property (p_ld) else $error("page load");
	property p_sv;
		wp && sfr_wdata_i[7:6] == 2'h2 ##1 rp |=>
			sfr_rdata_o[2:0] == $past(sfr_wdata_i[2:0], 2) && sfr_rdata_o[5:4] == $past(sfr_wdata_i[5:4], 2);
	endproperty
	a_sv: assert property (p_sv) else $error("page save");
	property p_rs; wp && sfr_wdata_i[7:6] == 2'h3 ##1 rp |=> sfr_rdata_o[5:4] == $past(sfr_wdata_i[5:4], 2); endproperty
	a_rs: assert property (p_rs) else $error("slot");
	property p_map; sfr_rd_i && register_map_select_i |=> sfr_rvalid_o && sfr_rdata_o == 8'h00; endproperty
	a_map: assert property (p_map) else $error("map");
	property p_rsv; rp |=> sfr_rdata_o[7:6] == 2'h0 && sfr_rdata_o[3] == 1'b0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits");
	property p_rst;
		disable iff (1'b0) rst_i |=> sfr_rdata_o == 8'h00 && !sfr_rvalid_o && pin_oe_o == 32'h0 && pin_out_o == 32'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values");
	property p_pin;
		pin_out_o[7:6] == 2'h0 && pin_oe_o[7:6] == 2'h0 && pin_out_o[12:10] == 3'h0 && pin_oe_o[12:10] == 3'h0;
	endproperty
	a_pin: assert property (p_pin) else $error("unimplemented pin bits");
endmodule
bind pgp_port_sfr pgp_port_sfr_props i_props (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.sfr_wr_i(sfr_wr_i),
	.sfr_rd_i(sfr_rd_i),
	.register_map_select_i(register_map_select_i),
	.sfr_rvalid_o(sfr_rvalid_o),
	.sfr_addr_i(sfr_addr_i),
	.sfr_wdata_i(sfr_wdata_i),
	.sfr_rdata_o(sfr_rdata_o),
	.pin_out_o(pin_out_o),
	.pin_oe_o(pin_oe_o)
);

// [tb/pgp_port_sfr_tb.sv]
`timescale 1ns/1ps
module pgp_port_sfr_tb;
	logic clk_i = 0, rst_i = 1, sfr_wr_i = 0, sfr_rd_i = 0, register_map_select_i = 0, sfr_rvalid_o;
	logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o;
	logic [31:0] pin_in_i = '1, pin_out_o, pin_oe_o;
	int n_fail = 0, n_tests = 0;
	pgp_port_sfr i_pgp_port_sfr (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sfr_addr_i(sfr_addr_i),
		.sfr_wr_i(sfr_wr_i),
		.sfr_rd_i(sfr_rd_i),
		.sfr_wdata_i(sfr_wdata_i),
		.register_map_select_i(register_map_select_i),
		.sfr_rdata_o(sfr_rdata_o),
		.sfr_rvalid_o(sfr_rvalid_o),
		.pin_in_i(pin_in_i),
		.pin_out_o(pin_out_o),
		.pin_oe_o(pin_oe_o)
	);
	always #5 clk_i = ~clk_i;
	task results;
		if (n_fail == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %0t mismatch seen %h expected %h", $time, s, e);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, d);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = w;
		sfr_rd_i = !w;
		@(negedge clk_i);
		if (!w) chk({sfr_rvalid_o, sfr_rdata_o}, {1'b1, d});
	endtask
	task t_rst;
		acc(1, 8'hb2, 8'h43);
		acc(0, 8'hb2, 8'h13);
		sfr_wr_i = 0;
		sfr_rd_i = 0;
		rst_i = 1;
		repeat (2) @(negedge clk_i);
		rst_i = 0;
		@(negedge clk_i);
		acc(0, 8'hb2, 8'h00);
		chk(pin_oe_o, 32'h0);
	endtask
	task t_page;
		acc(1, 8'hb2, 8'h05);
		acc(0, 8'hb2, 8'h05);
		acc(1, 8'hb2, 8'h9a);
		acc(0, 8'hb2, 8'h12);
		acc(1, 8'hb2, 8'hd7);
		acc(0, 8'hb2, 8'h15);
		acc(1, 8'hb2, 8'h1c);
		acc(0, 8'hb2, 8'h14);
		acc(0, 8'ha0, 8'h00);
		acc(1, 8'hb2, 8'h00);
	endtask
	task t_pin;
		acc(1, 8'h86, 8'hff);
		acc(1, 8'h91, 8'hff);
		acc(1, 8'h80, 8'hff);
		chk(pin_oe_o, 32'he33f);
		chk(pin_out_o, 32'h3f);
		acc(0, 8'h90, 8'he3);
	endtask
	task t_map;
		register_map_select_i = 1;
		acc(1, 8'h86, 8'h00);
		acc(0, 8'h86, 8'h00);
		register_map_select_i = 0;
		acc(0, 8'h86, 8'h3f);
	endtask
	initial begin
		repeat (6) @(negedge clk_i);
		rst_i = 0;
		@(negedge clk_i);
		acc(0, 8'hb2, 8'h00);
		t_page;
		t_pin;
		t_map;
		t_rst;
		results;
	end
	initial begin
		#5000;
		n_fail++;
		results;
	end
endmodule
